// file: tcc_link_master.sv
// Link master model: clocks one frame of bits out of the device.
// Assumes the device shows its first bit before the first pulse.
`timescale 1ns/1ps
module tcc_link_master
(
   // Link pins
   output logic serial_clk,
   input wire logic data_o,
   input wire logic data_oe
);
   // ------------------------------------------------
   // Frame clocking
   // ------------------------------------------------
   initial serial_clk = 1'b0;

   // Clock rests low between frames; sample at end of high phase
   task automatic receive(input int n, output logic [15:0] w,
                          output logic ok);
      begin
         #3;
         w = 16'h0000;
         ok = (data_oe === 1'b1);
         for (int i = 0; i < n; i++)
         begin
            serial_clk = 1'b1;
            #80;
            w = {w[14:0], data_o}; // First bit taken is the MSB
            ok = ok & (data_oe === 1'b1);
            serial_clk = 1'b0;
            #80;
         end
         #100;
         ok = ok & (data_oe === 1'b0) & (data_o === 1'b1);
      end
   endtask : receive
endmodule : tcc_link_master

// file: tcc_pkg.sv
// Package for the temperature conversion control block.
// Assumes a 100 MHz core clock and a 32-bit Avalon-MM register bus.
package tcc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 100000000;
   localparam int unsigned CONV_TIME_MS = 1000; // Longest conversion time
   localparam int unsigned NV_TIME_MS = 10; // Longest nonvolatile copy time
   localparam int unsigned CONV_CYCLES_DFLT = CONV_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned NV_CYCLES_DFLT = NV_TIME_MS * (CLK_HZ / 1000);

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_COMMAND = 8'h00;
   localparam logic [7:0] ADDR_FETCH = 8'h04;
   localparam logic [7:0] ADDR_CONFIG = 8'h08;
   localparam logic [7:0] ADDR_TEMP = 8'h0C;
   localparam logic [7:0] ADDR_HIGH_TRIP = 8'h10;
   localparam logic [7:0] ADDR_LOW_TRIP = 8'h14;
   localparam logic [7:0] ADDR_RESIDUAL = 8'h18;
   localparam logic [7:0] ADDR_SLOPE = 8'h1C;
   localparam logic [7:0] ADDR_SERIAL = 8'h20;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CMD_BEGIN_BIT = 0;
   localparam int CMD_HALT_BIT = 1;
   localparam int FETCH_TWO_BYTE_BIT = 2;
   localparam int CFG_DONE_BIT = 7;
   localparam int CFG_HIGH_FLAG_BIT = 6;
   localparam int CFG_LOW_FLAG_BIT = 5;
   localparam int CFG_NV_BUSY_BIT = 4;
   localparam int CFG_POL_BIT = 1;
   localparam int CFG_SINGLE_BIT = 0;

   // ----------------------------------------------------------------
   // Values and limits
   // ----------------------------------------------------------------
   localparam logic [8:0] TEMP_MIN = 9'h192; // -55 degrees in half steps
   localparam logic [8:0] TEMP_MAX = 9'h0FA; // +125 degrees in half steps
   localparam logic [8:0] HIGH_TRIP_RST = 9'h0FA;
   localparam logic [8:0] LOW_TRIP_RST = 9'h192;
   localparam logic CFG_POL_RST = 1'b1;
   localparam logic CFG_SINGLE_RST = 1'b0;

   typedef enum logic [1:0] {SRC_TEMP, SRC_RESIDUAL, SRC_SLOPE, SRC_CONFIG} tcc_src_e;

endpackage : tcc_pkg

// file: tcc_shift_if.sv
// Interface between the register side and the serial shifter.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface tcc_shift_if;
   logic load;
   logic [15:0] word;
   logic two_byte;
   logic busy;

   modport ctrl (output load, output word, output two_byte, input busy);
   modport shifter (input load, input word, input two_byte, output busy);
endinterface : tcc_shift_if

// file: tcc_shifter.sv
// Serial shifter: sends a loaded byte or word MSB first on the link.
// Assumes the link clock arrives from outside and is sampled by clk.
`timescale 1ns/1ps
module tcc_shifter
   import tcc_pkg::*;
(
   // Clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Link pins
   input wire logic link_clk,
   output logic data_o,
   output logic data_oe,
   // Register side
   tcc_shift_if.shifter sh
);

   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;
   logic [15:0] word_reg;
   logic [4:0] left_reg;
   logic fall;

   // ----------------------------------------------------------------
   // Link clock synchroniser and falling edge
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         prev_reg <= 1'b1;
      end
      else if (ce)
      begin
         sync1_reg <= link_clk;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   assign fall = prev_reg & ~sync2_reg;

   // ----------------------------------------------------------------
   // Shift register, one bit per falling link edge
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         word_reg <= 16'h0000;
         left_reg <= 5'h00;
         data_o <= 1'b1;
         data_oe <= 1'b0;
      end
      else if (ce)
      begin
         if (sh.load && left_reg == 5'h00)
         begin
            word_reg <= {sh.word[14:0], 1'b0};
            left_reg <= sh.two_byte ? 5'h10 : 5'h08;
            data_o <= sh.word[15];
            data_oe <= 1'b1;
         end
         else if (fall && left_reg != 5'h00)
         begin
            left_reg <= left_reg - 5'h01;
            word_reg <= {word_reg[14:0], 1'b0};
            data_o <= (left_reg == 5'h01) ? 1'b1 : word_reg[15];
            data_oe <= (left_reg != 5'h01);
         end
      end
   end

   assign sh.busy = (left_reg != 5'h00);

   a_shift_msb_first: assert property (@(posedge clk) disable iff (rst)
      (ce && sh.load && left_reg == 5'h00) |=> (data_oe && data_o == $past(sh.word[15])))
      else $error("first serial bit is not the MSB");

endmodule : tcc_shifter

// file: tcc_top.sv
// Temperature conversion control: conversion sequencing, result
// formatting, hysteresis thermostat and Avalon-MM register slave.
// Assumes the sensor front end presents its counts on clk.
//
// Contract
// - Temperature result is 9-bit two's complement, half-degree LSB, read on fetch.
// - Serial bytes leave most significant bit first.
// - Results cover -55 to +125 degrees in half-degree steps.
// - Values move as one byte or two bytes, both on reads and writes.
// - Second byte carries the half bit on top, lower seven bits zero.
// - Trip thresholds share the 9-bit temperature layout.
// - After power-up idle, no conversion until begin command.
// - Single-conversion select bit chooses continuous or one-shot.
// - Continuous mode converts back to back until halt, then idles.
// - Begin is accepted any time after a halt and resumes conversions.
// - One-shot mode makes exactly one conversion per begin, then idles.
// - Each conversion completes within one second.
// - Thermostat active above high trip, inactive once below low trip.
// - Thresholds kept in nonvolatile storage; here reset reloads them to HIGH_TRIP_RST and LOW_TRIP_RST.
// - Fetch residual and fetch slope return the last counts.
// - Select bit one means one-shot, zero means continuous.
// - Status shows conversion in progress or complete; in continuous mode done stays set through every conversion after the first.
// - Thermostat re-evaluated as each conversion completes.
// - In one-shot idle the thermostat holds its last state.
`timescale 1ns/1ps
module tcc_top
   import tcc_pkg::*;
#(
   parameter int unsigned CONV_CYCLES = CONV_CYCLES_DFLT,
   parameter int unsigned NV_CYCLES = NV_CYCLES_DFLT
)
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Sensor front end
   input wire logic [8:0] meas_temp,
   input wire logic [7:0] meas_residual,
   input wire logic [7:0] meas_slope,
   // Serial link
   input wire logic serial_clk,
   output logic serial_data_o,
   output logic serial_data_oe,
   // Thermostat pin
   output logic thermostat_out
);

   typedef enum logic {ST_IDLE, ST_CONV} tcc_state_e;

   tcc_state_e state_reg;
   logic [31:0] conv_cnt_reg;
   logic [31:0] nv_cnt_reg;
   logic [8:0] temp_reg;
   logic [7:0] residual_reg;
   logic [7:0] slope_reg;
   logic [8:0] high_trip_threshold;
   logic [8:0] low_trip_threshold;
   logic single_conversion_select;
   logic pol_reg;
   logic done_reg;
   logic high_flag_reg;
   logic low_flag_reg;
   logic active_reg;
   logic [8:0] clamped;
   logic wr_fire;
   logic rd_start;
   logic begin_cmd;
   logic halt_cmd;
   logic complete;
   logic fetch_go;
   logic [7:0] cfg_byte;
   logic [31:0] rd_mux;

   tcc_shift_if shift_bus ();

   // ----------------------------------------------------------------
   // Bus handshake: one wait cycle, then one ready cycle
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         avs_waitrequest <= 1'b1;
      else if (ce)
      begin
         if (!avs_waitrequest)
            avs_waitrequest <= 1'b1;
         else if (avs_read || avs_write)
            avs_waitrequest <= 1'b0;
      end
   end

   assign wr_fire = ce && avs_write && !avs_waitrequest;
   assign rd_start = ce && avs_read && avs_waitrequest;

   // Command decodes
   assign begin_cmd = wr_fire && avs_address == ADDR_COMMAND && avs_byteenable[0]
      && avs_writedata[CMD_BEGIN_BIT];
   assign halt_cmd = wr_fire && avs_address == ADDR_COMMAND && avs_byteenable[0]
      && avs_writedata[CMD_HALT_BIT];
   assign fetch_go = wr_fire && avs_address == ADDR_FETCH && avs_byteenable[0];
   assign complete = ce && state_reg == ST_CONV && conv_cnt_reg == CONV_CYCLES - 1;

   // Result held inside the documented range
   always_comb
   begin
      if ($signed(meas_temp) < $signed(TEMP_MIN))
         clamped = TEMP_MIN;
      else if ($signed(meas_temp) > $signed(TEMP_MAX))
         clamped = TEMP_MAX;
      else
         clamped = meas_temp;
   end

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= ST_IDLE;
         conv_cnt_reg <= 32'h00000000;
      end
      else if (ce)
      begin
         case (state_reg)
            ST_IDLE:
            begin
               conv_cnt_reg <= 32'h00000000;
               if (begin_cmd && !halt_cmd)
                  state_reg <= ST_CONV;
            end
            ST_CONV:
            begin
               if (halt_cmd)
                  state_reg <= ST_IDLE;
               else if (complete)
               begin
                  conv_cnt_reg <= 32'h00000000;
                  if (single_conversion_select)
                     state_reg <= ST_IDLE;
               end
               else
                  conv_cnt_reg <= conv_cnt_reg + 32'h00000001;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Results latched only when a conversion completes
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         temp_reg <= 9'h000;
         residual_reg <= 8'h00;
         slope_reg <= 8'h00;
      end
      else if (complete && !halt_cmd)
      begin
         temp_reg <= clamped;
         residual_reg <= meas_residual;
         slope_reg <= meas_slope;
      end
   end

   // Done status
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         done_reg <= 1'b1;
      else if (ce)
      begin
         if (state_reg == ST_IDLE && begin_cmd && !halt_cmd)
            done_reg <= 1'b0;
         else if (complete || halt_cmd)
            done_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Thermostat with hysteresis and high / low flags
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         active_reg <= 1'b0;
      else if (complete && !halt_cmd)
      begin
         if ($signed(clamped) >= $signed(high_trip_threshold))
            active_reg <= 1'b1;
         else if ($signed(clamped) < $signed(low_trip_threshold))
            active_reg <= 1'b0;
      end
   end

   // Pin follows polarity, holds between conversions
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         thermostat_out <= ~CFG_POL_RST;
      else if (ce)
         thermostat_out <= pol_reg ? active_reg : ~active_reg;
   end

   // Sticky flags, a new set wins over a clearing write
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         high_flag_reg <= 1'b0;
         low_flag_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (complete && !halt_cmd && $signed(clamped) >= $signed(high_trip_threshold))
            high_flag_reg <= 1'b1;
         else if (wr_fire && avs_address == ADDR_CONFIG && avs_byteenable[0]
            && !avs_writedata[CFG_HIGH_FLAG_BIT])
            high_flag_reg <= 1'b0;
         if (complete && !halt_cmd && $signed(clamped) <= $signed(low_trip_threshold))
            low_flag_reg <= 1'b1;
         else if (wr_fire && avs_address == ADDR_CONFIG && avs_byteenable[0]
            && !avs_writedata[CFG_LOW_FLAG_BIT])
            low_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Nonvolatile settings: thresholds, polarity, mode select
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         high_trip_threshold <= HIGH_TRIP_RST;
         low_trip_threshold <= LOW_TRIP_RST;
         pol_reg <= CFG_POL_RST;
         single_conversion_select <= CFG_SINGLE_RST;
      end
      else if (wr_fire && nv_cnt_reg == 32'h00000000)
      begin
         // One byte sets whole degrees, two bytes add the half bit
         if (avs_address == ADDR_HIGH_TRIP && avs_byteenable[1])
            high_trip_threshold <= {avs_writedata[15:8],
               avs_byteenable[0] & avs_writedata[7]};
         if (avs_address == ADDR_LOW_TRIP && avs_byteenable[1])
            low_trip_threshold <= {avs_writedata[15:8],
               avs_byteenable[0] & avs_writedata[7]};
         if (avs_address == ADDR_CONFIG && avs_byteenable[0])
         begin
            pol_reg <= avs_writedata[CFG_POL_BIT];
            single_conversion_select <= avs_writedata[CFG_SINGLE_BIT];
         end
      end
   end

   // Copy timer, settings writes refused while it runs
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         nv_cnt_reg <= 32'h00000000;
      else if (ce)
      begin
         if (nv_cnt_reg != 32'h00000000)
            nv_cnt_reg <= nv_cnt_reg - 32'h00000001;
         else if (wr_fire && ((avs_address == ADDR_HIGH_TRIP && avs_byteenable[1])
            || (avs_address == ADDR_LOW_TRIP && avs_byteenable[1])
            || (avs_address == ADDR_CONFIG && avs_byteenable[0])))
            nv_cnt_reg <= NV_CYCLES;
      end
   end

   // ----------------------------------------------------------------
   // Read mux and serial fetch
   // ----------------------------------------------------------------
   assign cfg_byte = {done_reg, high_flag_reg, low_flag_reg, nv_cnt_reg != 32'h00000000,
      2'b00, pol_reg, single_conversion_select};

   always_comb
   begin
      rd_mux = 32'h00000000;
      case (avs_address)
         ADDR_CONFIG: rd_mux = {24'h000000, cfg_byte};
         ADDR_TEMP: rd_mux = {16'h0000, temp_reg, 7'h00};
         ADDR_HIGH_TRIP: rd_mux = {16'h0000, high_trip_threshold, 7'h00};
         ADDR_LOW_TRIP: rd_mux = {16'h0000, low_trip_threshold, 7'h00};
         ADDR_RESIDUAL: rd_mux = {24'h000000, residual_reg};
         ADDR_SLOPE: rd_mux = {24'h000000, slope_reg};
         ADDR_SERIAL: rd_mux = {31'h00000000, shift_bus.busy};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         avs_readdata <= 32'h00000000;
      else if (rd_start)
         avs_readdata <= rd_mux;
   end

   // Fetch word, source in bits 1:0, length in bit 2
   always_comb
   begin
      case (tcc_src_e'(avs_writedata[1:0]))
         SRC_TEMP: shift_bus.word = {temp_reg, 7'h00};
         SRC_RESIDUAL: shift_bus.word = {residual_reg, 8'h00};
         SRC_SLOPE: shift_bus.word = {slope_reg, 8'h00};
         default: shift_bus.word = {cfg_byte, 8'h00};
      endcase
   end

   assign shift_bus.load = fetch_go;
   assign shift_bus.two_byte = avs_writedata[FETCH_TWO_BYTE_BIT];

   tcc_shifter u_shifter (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .link_clk(serial_clk),
      .data_o(serial_data_o),
      .data_oe(serial_data_oe),
      .sh(shift_bus.shifter)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_conv_time_bound: assert property (@(posedge clk) disable iff (rst)
      conv_cnt_reg <= CONV_CYCLES - 1)
      else $error("conversion ran past its time limit");

   a_begin_starts: assert property (@(posedge clk) disable iff (rst)
      (state_reg == ST_IDLE && begin_cmd && !halt_cmd) |=> (state_reg == ST_CONV && !done_reg))
      else $error("begin did not start a conversion");

   a_halt_goes_idle: assert property (@(posedge clk) disable iff (rst)
      halt_cmd |=> (state_reg == ST_IDLE && done_reg))
      else $error("halt did not return to idle");

   a_single_one_conv: assert property (@(posedge clk) disable iff (rst)
      (complete && !halt_cmd && single_conversion_select) |=> state_reg == ST_IDLE)
      else $error("one-shot mode kept converting");

   a_cont_keeps_going: assert property (@(posedge clk) disable iff (rst)
      (complete && !halt_cmd && !single_conversion_select)
      |=> (state_reg == ST_CONV && conv_cnt_reg == 32'h00000000))
      else $error("continuous mode stopped");

   a_temp_held: assert property (@(posedge clk) disable iff (rst)
      !(complete && !halt_cmd) |=> $stable(temp_reg))
      else $error("result changed without a completed conversion");

   a_range_kept: assert property (@(posedge clk) disable iff (rst)
      ($signed(temp_reg) >= $signed(TEMP_MIN) && $signed(temp_reg) <= $signed(TEMP_MAX)))
      else $error("result outside the measurable range");

   a_trip_high: assert property (@(posedge clk) disable iff (rst)
      (complete && !halt_cmd && $signed(clamped) >= $signed(high_trip_threshold))
      ##1 ce |=> thermostat_out == pol_reg)
      else $error("thermostat not active above high trip");

endmodule : tcc_top

// file: tcc_top_tb.sv
// Testbench for the temperature conversion control block.
// Assumes the link master model is compiled before this file.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   $display("[FAIL] %s exp %h got %h", nm, e, g); n_mismatch++; end end
module tcc_top_tb
   import tcc_pkg::*;
;
   localparam int CONV = 20;
   localparam int LIMIT = 30000;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [3:0] avs_byteenable = 4'h0;
   logic avs_waitrequest, serial_clk, serial_data_o, serial_data_oe;
   logic thermostat_out, ok, therm, two;
   logic [8:0] meas_temp = 9'h000, t, tc;
   logic [7:0] meas_residual = 8'h00, meas_slope = 8'h00, res, slp;
   logic [15:0] w, e;
   logic [8:0] corner [8] = '{9'h0FA, 9'h192, 9'h1FF, 9'h03D,
                              9'h029, 9'h028, 9'h027, 9'h100};
   int n_mismatch = 0, n_compared = 0, cycles = 0, seed = 32'hD809;

   // ------------------------------------------------
   // Design and link partner
   // ------------------------------------------------
   tcc_top #(.CONV_CYCLES(CONV), .NV_CYCLES(5)) dut (.clk(clk), .rst(rst),
      .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .meas_temp(meas_temp),
      .meas_residual(meas_residual), .meas_slope(meas_slope),
      .serial_clk(serial_clk), .serial_data_o(serial_data_o),
      .serial_data_oe(serial_data_oe), .thermostat_out(thermostat_out));
   tcc_link_master link (.serial_clk(serial_clk), .data_o(serial_data_o),
      .data_oe(serial_data_oe));

   // Clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         n_mismatch++;
         complete_run();
      end
   end

   // ------------------------------------------------
   // Expectations and bus tasks
   // ------------------------------------------------
   function automatic logic [8:0] clamp(input logic [8:0] v);
      if ($signed(v) < $signed(TEMP_MIN)) return TEMP_MIN;
      if ($signed(v) > $signed(TEMP_MAX)) return TEMP_MAX;
      return v;
   endfunction : clamp

   // Hysteresis: set at or above high, clear only below low
   function automatic logic th_next(input logic s, input logic [8:0] v);
      if ($signed(v) >= $signed(9'h03D)) return 1'b1;
      if ($signed(v) < $signed(9'h028)) return 1'b0;
      return s;
   endfunction : th_next

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      begin
         avs_address <= a;
         avs_write <= wr;
         avs_read <= !wr;
         avs_writedata <= d;
         avs_byteenable <= be;
         do
         begin
            @(posedge clk);
         end while (avs_waitrequest !== 1'b0);
         rd = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         @(posedge clk);
      end
   endtask : bus

   task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input string nm);
      bus(1'b0, a, 32'h0, 4'hF);
      `CHK(nm, x, rd)
   endtask : rdchk

   // Poll until settings copy or conversion finishes
   task automatic poll(input int bit_i, input logic want);
      for (int i = 0; i < CONV; i++)
      begin
         bus(1'b0, ADDR_CONFIG, 32'h0, 4'hF);
         if (rd[bit_i] === want) break;
      end
      `CHK("status", want, rd[bit_i])
   endtask : poll

   task automatic convert(input logic [8:0] v);
      meas_temp <= v;
      res = 8'($random(seed));
      slp = 8'($random(seed));
      meas_residual <= res;
      meas_slope <= slp;
      bus(1'b1, ADDR_COMMAND, 32'h1, 4'h1);
      poll(CFG_DONE_BIT, 1'b1);
   endtask : convert

   task automatic complete_run;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   // ------------------------------------------------
   // Test sequence
   // ------------------------------------------------
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdchk(ADDR_CONFIG, 32'h82, "config");
      rdchk(ADDR_HIGH_TRIP, 32'h7D00, "high");
      rdchk(ADDR_LOW_TRIP, 32'hC900, "low");
      rdchk(8'h40, 32'h0, "unmapped");
      meas_temp <= TEMP_MAX;
      repeat (3 * CONV) @(posedge clk);
      rdchk(ADDR_CONFIG, 32'h82, "idle");
      $display("test reset done");
      bus(1'b1, ADDR_HIGH_TRIP, 32'h1E80, 4'h3);
      poll(CFG_NV_BUSY_BIT, 1'b0);
      bus(1'b1, ADDR_LOW_TRIP, 32'h14FF, 4'h2);
      poll(CFG_NV_BUSY_BIT, 1'b0);
      rdchk(ADDR_HIGH_TRIP, 32'h1E80, "high2");
      rdchk(ADDR_LOW_TRIP, 32'h1400, "low1");
      bus(1'b1, ADDR_CONFIG, 32'h03, 4'h1);
      poll(CFG_NV_BUSY_BIT, 1'b0);
      $display("test thresholds done");
      therm = 1'b0;
      for (int i = 0; i < 20; i++)
      begin
         t = (i < 8) ? corner[i] : 9'($random(seed));
         convert(t);
         tc = clamp(t);
         therm = th_next(therm, tc);
         rdchk(ADDR_TEMP, {16'h0, tc, 7'h00}, "temp");
         rdchk(ADDR_RESIDUAL, {24'h0, res}, "residual");
         rdchk(ADDR_SLOPE, {24'h0, slp}, "slope");
         `CHK("thermostat", therm, thermostat_out)
         two = i[0];
         bus(1'b1, ADDR_FETCH, {29'h0, two, 2'(i % 3)}, 4'h1);
         link.receive(two ? 16 : 8, w, ok);
         e = (i % 3 == 0) ? {tc, 7'h00} : (i % 3 == 1) ? {res, 8'h00} : {slp, 8'h00};
         if (!two) e = {8'h00, e[15:8]};
         `CHK("serial", e, w)
         `CHK("frame", 1'b1, ok)
      end
      meas_temp <= 9'h000;
      repeat (3 * CONV) @(posedge clk);
      rdchk(ADDR_TEMP, {16'h0, tc, 7'h00}, "single");
      `CHK("hold", therm, thermostat_out)
      rdchk(ADDR_CONFIG, 32'hE3, "flags");
      $display("test one-shot done");
      bus(1'b1, ADDR_CONFIG, 32'h02, 4'h1);
      poll(CFG_NV_BUSY_BIT, 1'b0);
      convert(9'h032);
      meas_temp <= 9'h04B;
      repeat (3 * CONV + 10) @(posedge clk);
      rdchk(ADDR_TEMP, 32'h2580, "running");
      `CHK("active", 1'b1, thermostat_out)
      bus(1'b1, ADDR_COMMAND, 32'h2, 4'h1);
      meas_temp <= 9'h010;
      repeat (3 * CONV) @(posedge clk);
      rdchk(ADDR_TEMP, 32'h2580, "halted");
      convert(9'h010);
      rdchk(ADDR_TEMP, 32'h0800, "resumed");
      `CHK("released", 1'b0, thermostat_out)
      bus(1'b1, ADDR_CONFIG, 32'h00, 4'h1);
      poll(CFG_NV_BUSY_BIT, 1'b0);
      `CHK("inverted", 1'b1, thermostat_out)
      ce <= 1'b0;
      meas_temp <= 9'h04B;
      repeat (3 * CONV) @(posedge clk);
      `CHK("frozen", 1'b1, thermostat_out)
      ce <= 1'b1;
      $display("test continuous done");
      complete_run();
   end
endmodule : tcc_top_tb
